// ### hdl/vrcw_pkg.sv
// Purpose: shared constants and types of the volatile read configuration block
// Assumes: one 40 MHz clock; serial pins sampled, never used as a clock
// Notes: configuration byte is dummy[7:4], in-place disable[3], zero[2], wrap[1:0]
// Notes on behaviour
// - read/write commands; working config reloads after either
// - written value takes effect when write completes
// - reset reloads configuration from nonvolatile settings
// - bits 7:4 give fast read dummy count
// - too few dummy cycles gives invalid data
// - bit 3 low enables execute in place
// - wrap 00 wraps inside aligned 16 bytes
// - wrap 01 wraps inside aligned 32 bytes
// - wrap 10 wraps inside aligned 64 bytes
// - wrap 11 counts through whole array
// - tuning pattern lets host adjust latching point
package vrcw_pkg;

  localparam int          ADDR_W      = 24;    // array address width
  localparam int          DUMMY_HI    = 7;     // dummy count field
  localparam int          DUMMY_LO    = 4;
  localparam int          IN_PLACE_BIT = 3;    // execute in place, low enables
  localparam int          RSV_BIT     = 2;     // reserved, fixed zero
  localparam int          WRAP_HI     = 1;     // wrap field
  localparam int          WRAP_LO     = 0;
  localparam logic [1:0]  WRAP_16     = 2'h0;
  localparam logic [1:0]  WRAP_32     = 2'h1;
  localparam logic [1:0]  WRAP_64     = 2'h2;
  localparam logic [1:0]  WRAP_CONT   = 2'h3;  // value after reset
  localparam logic [3:0]  DUMMY_ZERO  = 4'h0;  // code taken as the longest count
  localparam logic [3:0]  DUMMY_MAX   = 4'hf;
  localparam logic [2:0]  BIT_LAST    = 3'h7;  // last bit of a byte
  localparam logic [1:0]  ADDR_LAST   = 2'h2;  // third address byte

  // serial frame states
  typedef enum logic [2:0] {
    ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_WRCFG, ST_RDCFG, ST_IDLE
  } vrcw_state_t;

  // synchronised pins
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic si;
  } vrcw_pins_t;

  // whole state of the block
  typedef struct packed {
    vrcw_state_t        st;         // frame state
    logic [2:0]         bitcnt;     // bit within byte
    logic [1:0]         bytecnt;    // address byte count
    logic [3:0]         dcnt;       // dummy cycles left
    logic [7:0]         sh_in;      // receive shift
    logic [7:0]         sh_out;     // transmit shift
    logic [ADDR_W-1:0]  addr;       // read address
    logic [7:0]         vol_cfg;    // volatile register
    logic [7:0]         act_cfg;    // working configuration
    logic [7:0]         pend;       // written byte awaiting frame end
    logic               wr_pend;    // a full byte was written
    logic               tune;       // frame returns tuning pattern
    logic               in_place_armed;  // next frame starts with address
    logic               sclk_q;     // previous sampled clock
    logic               so;         // serial output
    logic               so_oe_n;    // output enable, low drives
  } vrcw_regs_t;

  // effective dummy count: zero code means the longest count
  function automatic logic [3:0] vrcw_eff_dummy(input logic [3:0] d);
    return (d == DUMMY_ZERO) ? DUMMY_MAX : d;
  endfunction

  // next read address under the wrap setting
  function automatic logic [ADDR_W-1:0] vrcw_next_addr(input logic [ADDR_W-1:0] a,
                                                       input logic [1:0] w);
    logic [ADDR_W-1:0] m;
    logic [ADDR_W-1:0] inc;
    m   = '1;
    inc = a + {{(ADDR_W-1){1'b0}}, 1'b1};
    case (w)
      WRAP_16: m = 24'h00000f;
      WRAP_32: m = 24'h00001f;
      WRAP_64: m = 24'h00003f;
      default: m = '1;
    endcase
    return (a & ~m) | (inc & m);
  endfunction

endpackage

// ### hdl/vrcw_sync.sv
// Purpose: two-stage synchroniser for the serial pins
// Assumes: inputs asynchronous to ref_clk_i
// Notes: first stage is read by the second stage only
module vrcw_sync import vrcw_pkg::*; #(
  parameter int W = 3
) (
  input  wire logic         ref_clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_reg;  // first stage

  // two flops per pin; idle level is all ones (clock high, select off)
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      meta_reg <= '1;
      sync_o   <= '1;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end

endmodule

// ### hdl/vrcw_top.sv
// Purpose: volatile read configuration register of a serial flash, serial side
// Assumes: serial mode 0, one data line in, one out; array read port outside
// Notes: sclk is sampled by ref_clk_i, so it must stay below a quarter of it
module vrcw_top import vrcw_pkg::*; #(
  parameter logic [7:0] CMD_RD_CFG = 8'h11,  // read configuration opcode
  parameter logic [7:0] CMD_WR_CFG = 8'h12,  // write configuration opcode
  parameter logic [7:0] CMD_FAST   = 8'h13,  // fast read opcode
  parameter logic [7:0] CMD_TUNE   = 8'h14,  // tuning pattern opcode
  parameter logic [7:0] TUNE_BYTE  = 8'h5a   // tuning pattern byte
) (
  input  wire logic              ref_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              sclk_i,
  input  wire logic              cs_n_i,
  input  wire logic              si_i,
  input  wire logic [3:0]        nv_dummy_i,
  input  wire logic              nv_in_place_dis_i,
  input  wire logic [7:0]        mem_data_i,
  output logic                   so_o,
  output logic                   so_oe_n_o,
  output logic [ADDR_W-1:0]      mem_addr_o,
  output logic                   execute_in_place_o,
  output logic [3:0]             cfg_dummy_o,
  output logic [1:0]             cfg_wrap_o
);

  logic [2:0]  pins_raw;   // synchroniser output
  vrcw_pins_t  pins;       // synchronised pins
  vrcw_regs_t  st_reg;     // registered state
  vrcw_regs_t  st_next;    // next state
  logic        rise;       // sampled clock rising
  logic        fall;       // sampled clock falling
  logic [7:0]  rx_byte;    // byte completed on this edge
  logic [7:0]  nv_cfg;     // configuration loaded at reset
  logic [7:0]  rd_byte;    // next byte of read data

  // pins pass two flops before any logic
  vrcw_sync #(.W(3)) u_sync (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   ({sclk_i, cs_n_i, si_i}),
    .sync_o    (pins_raw)
  );

  assign pins    = vrcw_pins_t'(pins_raw);
  assign rise    = pins.sclk & ~st_reg.sclk_q;
  assign fall    = ~pins.sclk & st_reg.sclk_q;
  assign rx_byte = {st_reg.sh_in[6:0], pins.si};
  assign nv_cfg  = {nv_dummy_i, nv_in_place_dis_i, 1'b0, WRAP_CONT};
  assign rd_byte = st_reg.tune ? TUNE_BYTE : mem_data_i;

  // next-state logic of the whole block
  always_comb begin
    st_next        = st_reg;
    st_next.sclk_q = pins.sclk;
    if (sys_rst_i) begin
      // reset reloads from nonvolatile settings, volatile value is lost
      st_next           = '0;
      st_next.st        = ST_CMD;
      st_next.vol_cfg   = nv_cfg;
      st_next.act_cfg   = nv_cfg;
      st_next.sclk_q    = 1'b1;
      st_next.so_oe_n   = 1'b1;
    end else if (pins.cs_n) begin
      // frame end: completed write takes effect, read reloads working copy
      if (st_reg.st == ST_WRCFG && st_reg.wr_pend) begin
        st_next.vol_cfg = st_reg.pend;
        st_next.act_cfg = st_reg.pend;
      end else if (st_reg.st == ST_RDCFG) begin
        st_next.act_cfg = st_reg.vol_cfg;
      end
      st_next.st      = st_reg.in_place_armed ? ST_ADDR : ST_CMD;
      st_next.bitcnt  = '0;
      st_next.bytecnt = '0;
      st_next.wr_pend = 1'b0;
      st_next.tune    = 1'b0;
      st_next.so_oe_n = 1'b1;
    end else if (rise) begin
      // sample input on rising clock
      st_next.sh_in  = rx_byte;
      st_next.bitcnt = st_reg.bitcnt + 3'h1;
      if (st_reg.st == ST_DUMMY) begin
        // first dummy bit high leaves execute in place
        if (st_reg.dcnt == vrcw_eff_dummy(st_reg.act_cfg[DUMMY_HI:DUMMY_LO])) begin
          st_next.in_place_armed = ~pins.si & ~st_reg.act_cfg[IN_PLACE_BIT]
                                   & ~st_reg.tune;
        end
        if (st_reg.dcnt == 4'h1) begin
          // data starts after the configured dummy count, valid or not
          st_next.st     = ST_DATA;
          st_next.bitcnt = '0;
          st_next.sh_out = rd_byte;
          if (!st_reg.tune) begin
            st_next.addr = vrcw_next_addr(st_reg.addr, st_reg.act_cfg[WRAP_HI:WRAP_LO]);
          end
        end else begin
          st_next.dcnt = st_reg.dcnt - 4'h1;
        end
      end else if (st_reg.bitcnt == BIT_LAST) begin
        case (st_reg.st)
          ST_CMD: begin
            // decode opcode
            if (rx_byte == CMD_RD_CFG) begin
              st_next.st     = ST_RDCFG;
              st_next.sh_out = st_reg.vol_cfg;
            end else if (rx_byte == CMD_WR_CFG) begin
              st_next.st = ST_WRCFG;
            end else if (rx_byte == CMD_FAST) begin
              st_next.st = ST_ADDR;
            end else if (rx_byte == CMD_TUNE) begin
              st_next.st   = ST_DUMMY;
              st_next.tune = 1'b1;
              st_next.dcnt = vrcw_eff_dummy(st_reg.act_cfg[DUMMY_HI:DUMMY_LO]);
            end else begin
              st_next.st = ST_IDLE;
            end
          end
          ST_ADDR: begin
            // three address bytes, most significant first
            st_next.addr    = {st_reg.addr[15:0], rx_byte};
            st_next.bytecnt = st_reg.bytecnt + 2'h1;
            if (st_reg.bytecnt == ADDR_LAST) begin
              st_next.st   = ST_DUMMY;
              st_next.dcnt = vrcw_eff_dummy(st_reg.act_cfg[DUMMY_HI:DUMMY_LO]);
            end
          end
          ST_WRCFG: begin
            // first byte only; reserved bit forced to zero
            if (!st_reg.wr_pend) begin
              st_next.pend          = rx_byte;
              st_next.pend[RSV_BIT] = 1'b0;
              st_next.wr_pend       = 1'b1;
            end
          end
          ST_RDCFG: begin
            st_next.sh_out = st_reg.vol_cfg;       // repeats while selected
          end
          ST_DATA: begin
            // next byte under the wrap setting
            st_next.sh_out = rd_byte;
            if (!st_reg.tune) begin
              st_next.addr = vrcw_next_addr(st_reg.addr,
                                            st_reg.act_cfg[WRAP_HI:WRAP_LO]);
            end
          end
          default: begin
            st_next.st = ST_IDLE;                  // unknown opcode ignored
          end
        endcase
      end
    end else if (fall && (st_reg.st == ST_DATA || st_reg.st == ST_RDCFG)) begin
      // shift out on falling clock
      st_next.so      = st_reg.sh_out[7];
      st_next.sh_out  = {st_reg.sh_out[6:0], 1'b0};
      st_next.so_oe_n = 1'b0;
    end
    if (st_next.act_cfg[IN_PLACE_BIT]) begin
      st_next.in_place_armed = 1'b0;
    end
  end

  // state register
  always_ff @(posedge ref_clk_i) begin
    st_reg <= st_next;
  end

  // outputs come straight from the state register
  assign so_o               = st_reg.so;
  assign so_oe_n_o          = st_reg.so_oe_n;
  assign mem_addr_o         = st_reg.addr;
  assign execute_in_place_o = ~st_reg.act_cfg[IN_PLACE_BIT];
  assign cfg_dummy_o        = st_reg.act_cfg[DUMMY_HI:DUMMY_LO];
  assign cfg_wrap_o         = st_reg.act_cfg[WRAP_HI:WRAP_LO];

  // helper: dummy edges seen in the current dummy phase
  logic [4:0] dseen_reg;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || st_reg.st != ST_DUMMY) begin
      dseen_reg <= '0;
    end else if (rise && !pins.cs_n) begin
      dseen_reg <= dseen_reg + 5'h1;
    end
  end

  logic adv;  // address stepped during data
  assign adv = st_reg.st == ST_DATA && st_next.addr != st_reg.addr && !pins.cs_n;

  a_rsv_zero: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !st_reg.vol_cfg[RSV_BIT] && !st_reg.act_cfg[RSV_BIT])
    else $error("reserved bit not zero");
  a_reset_load: assert property (@(posedge ref_clk_i)
    sys_rst_i |=> st_reg.act_cfg == {$past(nv_dummy_i), $past(nv_in_place_dis_i), 3'h3}
                  && st_reg.st == ST_CMD && so_oe_n_o)
    else $error("reset did not load nonvolatile settings");
  a_write_apply: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (st_reg.st == ST_WRCFG && st_reg.wr_pend && pins.cs_n)
      |=> st_reg.act_cfg == $past(st_reg.pend) && st_reg.vol_cfg == $past(st_reg.pend))
    else $error("written value not applied at frame end");
  a_read_reload: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (st_reg.st == ST_RDCFG && pins.cs_n) |=> st_reg.act_cfg == $past(st_reg.vol_cfg))
    else $error("read did not reload working configuration");
  a_dummy_len: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (st_reg.st == ST_DUMMY && st_next.st == ST_DATA)
      |-> dseen_reg + 5'h1 == {1'b0, vrcw_eff_dummy(cfg_dummy_o)})
    else $error("dummy phase length wrong");
  a_in_place_armed: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    st_reg.in_place_armed |-> execute_in_place_o)
    else $error("armed while execute in place disabled");
  a_wrap_16: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (adv && cfg_wrap_o == WRAP_16) |=> mem_addr_o[23:4] == $past(mem_addr_o[23:4]))
    else $error("16 byte wrap left its block");
  a_wrap_32: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (adv && cfg_wrap_o == WRAP_32) |=> mem_addr_o[23:5] == $past(mem_addr_o[23:5]))
    else $error("32 byte wrap left its block");
  a_wrap_64: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (adv && cfg_wrap_o == WRAP_64) |=> mem_addr_o[23:6] == $past(mem_addr_o[23:6]))
    else $error("64 byte wrap left its block");
  a_wrap_cont: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (adv && cfg_wrap_o == WRAP_CONT) |=> mem_addr_o == $past(mem_addr_o) + 24'h1)
    else $error("continuous read did not increment");
  a_tune_data: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (st_reg.tune && st_next.st == ST_DATA && st_reg.st == ST_DUMMY)
      |=> st_reg.sh_out == TUNE_BYTE)
    else $error("tuning pattern not loaded");

  c_write: cover property (@(posedge ref_clk_i)
    st_reg.st == ST_WRCFG && st_reg.wr_pend && pins.cs_n);
  c_wrap: cover property (@(posedge ref_clk_i)
    adv && mem_addr_o[3:0] == 4'hf && cfg_wrap_o == WRAP_16);
  c_in_place: cover property (@(posedge ref_clk_i) st_reg.in_place_armed && pins.cs_n);
  c_tune: cover property (@(posedge ref_clk_i) st_reg.tune && st_reg.st == ST_DATA);

endmodule

// ### sim/vrcw_host.sv
// Purpose: host serial controller model that clocks the configuration block
// Assumes: mode 0, link clock made from ref_clk_i, 8 ref clocks a period (200 ns)
// Notes: low phase 5 clocks, high phase 3; so is taken at the end of the low phase
module vrcw_host (
  input  wire logic ref_clk_i,  // system clock the model steps on
  input  wire logic so_i,       // serial data from the block
  output logic      sclk_o,     // link clock, rests low outside frames
  output logic      cs_n_o,     // chip select, active low
  output logic      si_o        // serial data to the block
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle link at time zero
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o   = 1'b0;
  end

  // open a frame, leaving room before the first clock
  task automatic open_frame();
    @(posedge ref_clk_i) cs_n_o <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
  endtask

  // close a frame and keep the gap the block needs between frames
  task automatic close_frame();
    repeat (4) @(posedge ref_clk_i);
    cs_n_o <= 1'b1;
    si_o   <= ~si_o;  // released data line does not keep its last level
    repeat (8) @(posedge ref_clk_i);
  endtask

  // shift n bits of d out msb first and collect so into q
  task automatic shift(input int n, input logic [7:0] d, output logic [7:0] q);
    q = 8'h00;
    for (int i = n - 1; i >= 0; i--) begin
      si_o <= d[i];
      repeat (5) @(posedge ref_clk_i);  // 5 MHz link, far below any read limit
      q[i] = so_i;
      sclk_o <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      sclk_o <= 1'b0;
    end
  endtask
endmodule

// ### sim/vrcw_top_test.sv
// Purpose: self-checking bench of the volatile read configuration block
// Assumes: array model returns address low byte xor 3c, one clock after the address
// Notes: expected bytes are computed here from the register layout and wrap sizes
module vrcw_top_test import vrcw_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic              ref_clk, sys_rst, sclk, cs_n, si, nv_in_place_dis, so, so_oe_n, in_place;
  logic [3:0]        nv_dummy, cfg_dummy;  // nonvolatile and working dummy codes
  logic [1:0]        cfg_wrap;             // working wrap field
  logic [7:0]        mem_data, q;          // array byte, scratch read byte
  logic [ADDR_W-1:0] mem_addr;             // read address from the block
  int                fail_count = 0;
  int                samples_checked = 0;

  vrcw_top i_vrcw_top (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .sclk_i(sclk),
    .cs_n_i(cs_n), .si_i(si), .nv_dummy_i(nv_dummy), .nv_in_place_dis_i(nv_in_place_dis),
    .mem_data_i(mem_data), .so_o(so), .so_oe_n_o(so_oe_n), .mem_addr_o(mem_addr),
    .execute_in_place_o(in_place), .cfg_dummy_o(cfg_dummy), .cfg_wrap_o(cfg_wrap));
  vrcw_host i_vrcw_host (.ref_clk_i(ref_clk), .so_i(so), .sclk_o(sclk), .cs_n_o(cs_n),
    .si_o(si));

  // 40 MHz clock
  initial ref_clk = 1'b0;
  always #12.5 ref_clk = ~ref_clk;
  // array model
  always @(posedge ref_clk) mem_data <= mem_addr[7:0] ^ 8'h3c;

  // compare one byte
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // working configuration in register layout
  function automatic logic [7:0] cfg_view();
    return {cfg_dummy, ~in_place, 1'b0, cfg_wrap};
  endfunction
  // write the volatile register in one frame
  task automatic wr_cfg(input logic [7:0] v);
    i_vrcw_host.open_frame();
    i_vrcw_host.shift(8, i_vrcw_top.CMD_WR_CFG, q);
    i_vrcw_host.shift(8, v, q);
    i_vrcw_host.close_frame();
  endtask
  // read the volatile register and compare it
  task automatic rd_cfg(input logic [7:0] exp);
    i_vrcw_host.open_frame();
    i_vrcw_host.shift(8, i_vrcw_top.CMD_RD_CFG, q);
    i_vrcw_host.shift(8, 8'hff, q);
    i_vrcw_host.close_frame();
    check_byte(q, exp);
  endtask
  // fast read of nb bytes from a with nd dummy clocks; m is the wrap mask
  task automatic fast_read(input logic op, input logic [23:0] a, input int nd, input int nb,
                           input logic [23:0] m, input logic arm_n);
    logic [23:0] e;
    e = a;
    i_vrcw_host.open_frame();
    if (op) i_vrcw_host.shift(8, i_vrcw_top.CMD_FAST, q);
    for (int i = 2; i >= 0; i--) i_vrcw_host.shift(8, a[8*i +: 8], q);
    i_vrcw_host.shift(1, {7'h00, arm_n}, q);  // first dummy bit picks in-place arming
    if (nd > 1) i_vrcw_host.shift(nd - 1, 8'hff, q);
    for (int i = 0; i < nb; i++) begin
      i_vrcw_host.shift(8, 8'hff, q);
      check_byte(q, e[7:0] ^ 8'h3c);
      e = (e & ~m) | ((e + 24'h000001) & m);
    end
    i_vrcw_host.close_frame();
  endtask

  // values loaded by reset
  task automatic test_reset();
    check_byte(cfg_view(), 8'h2b);
    check_byte({7'h00, so_oe_n}, 8'h01);
    rd_cfg(8'h2b);
    $display("test reset done");
  endtask
  // written value applies at once, reserved bit reads zero, short write and
  // unknown opcode leave the configuration alone
  task automatic test_write();
    wr_cfg(8'h3f);
    check_byte(cfg_view(), 8'h3b);
    rd_cfg(8'h3b);
    i_vrcw_host.open_frame();
    i_vrcw_host.shift(8, i_vrcw_top.CMD_WR_CFG, q);
    i_vrcw_host.shift(4, 8'h05, q);
    i_vrcw_host.close_frame();
    check_byte(cfg_view(), 8'h3b);
    i_vrcw_host.open_frame();
    i_vrcw_host.shift(8, 8'h00, q);
    i_vrcw_host.shift(8, 8'h00, q);
    i_vrcw_host.close_frame();
    check_byte(cfg_view(), 8'h3b);
    $display("test write done");
  endtask
  // every wrap mode, each with its own dummy count, crossing 16/32/64 borders
  task automatic test_wrap();
    logic [23:0] m;
    for (int w = 0; w < 4; w++) begin
      m = (w == 3) ? 24'hffffff : (24'h000010 << w) - 24'h000001;
      wr_cfg({4'(w + 1), 1'b1, 1'b0, 2'(w)});
      check_byte(cfg_view(), {4'(w + 1), 1'b1, 1'b0, 2'(w)});
      fast_read(1'b1, 24'h00001d, w + 1, 36, m, 1'b1);
    end
    $display("test wrap done");
  endtask
  // tuning pattern after code 0000 dummy clocks, taken as 15
  task automatic test_tune();
    wr_cfg(8'h0b);
    i_vrcw_host.open_frame();
    i_vrcw_host.shift(8, i_vrcw_top.CMD_TUNE, q);
    i_vrcw_host.shift(8, 8'hff, q);
    i_vrcw_host.shift(7, 8'hff, q);
    for (int i = 0; i < 2; i++) begin
      i_vrcw_host.shift(8, 8'hff, q);
      check_byte(q, i_vrcw_top.TUNE_BYTE);
    end
    i_vrcw_host.close_frame();
    $display("test tune done");
  endtask
  // execute in place: armed frame is followed by one without opcode
  task automatic test_in_place();
    wr_cfg(8'h23);
    check_byte(cfg_view(), 8'h23);
    fast_read(1'b1, 24'h000040, 2, 2, 24'hffffff, 1'b0);
    fast_read(1'b0, 24'h000080, 2, 2, 24'hffffff, 1'b1);
    rd_cfg(8'h23);
    $display("test in place done");
  endtask
  // reset in mid-run reloads the nonvolatile settings
  task automatic test_rst();
    nv_dummy   <= 4'h5;
    nv_in_place_dis <= 1'b0;
    @(posedge ref_clk) sys_rst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check_byte(cfg_view(), 8'h53);
    rd_cfg(8'h53);
    $display("test mid-run reset done");
  endtask

  // verdict and end of run
  task automatic tally_and_finish();
    $display("checked %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // main sequence
  initial begin
    sys_rst    = 1'b1;
    nv_dummy   = 4'h2;
    nv_in_place_dis = 1'b1;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    test_reset();
    test_write();
    test_wrap();
    test_tune();
    test_in_place();
    test_rst();
    tally_and_finish();
  end

  // watchdog, about four and a half times the expected run
  initial begin
    repeat (60000) @(posedge ref_clk);
    fail_count++;
    tally_and_finish();
  end
endmodule
